// ### src/eif_chan.sv
`timescale 1ns/1ps
// =====================================================================
// One channel: noise filter, edge selector and level flag
// =====================================================================
module eif_chan (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               gate_en,     // Channel clock running
	input  wire logic               slow_mode,   // Low-speed mode
	input  wire logic               sample_tick, // Filter sample enable
	input  wire eif_pkg::eif_edge_t edge_sel,    // Requested edge kind
	input  wire logic               pin,         // Raw interrupt input
	output logic                    req,         // One-cycle request
	output logic                    level_flag   // Level at last request
);
	import eif_pkg::*;

	typedef struct packed {
		logic [1:0] run;  // Consecutive samples disagreeing with filt
		logic       filt; // Filtered level
		logic       req;  // Request pulse
		logic       lvl;  // Level captured at request
	} eif_chan_st_t;

	eif_chan_st_t s_q, s_d;
	logic [1:0]   need;
	logic         hit;

	// =================================================================
	// Filter and edge qualification
	// =================================================================
	always_comb begin
		s_d     = s_q;
		s_d.req = 1'b0;
		hit     = 1'b0;
		need    = slow_mode ? NEED_SLOW : NEED_FAST;
		if (!gate_en) begin
			// Stopped clock forgets everything
			s_d = '0;
		end else if (sample_tick) begin
			if (pin == s_q.filt) begin
				s_d.run = 2'h0; // Short glitch rejected
			end else if (s_q.run + 2'h1 == need) begin
				s_d.run  = 2'h0;
				s_d.filt = pin;
				// New level compared with the old one
				case (edge_sel)
					ES_RISE: hit = pin;
					ES_FALL: hit = !pin;
					ES_BOTH: hit = 1'b1;
					default: hit = 1'b0;   // Reserved: no request
				endcase
				s_d.req = hit;
				if (hit) begin
					s_d.lvl = pin;
				end
			end else begin
				s_d.run = s_q.run + 2'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign req        = s_q.req;
	assign level_flag = s_q.lvl;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_req_single: assert property (req |=> !req)
		else $error("request longer than one cycle");
	a_rise_only: assert property (req && $past(edge_sel) == ES_RISE |-> level_flag)
		else $error("rising request on low level");
	a_fall_only: assert property (req && $past(edge_sel) == ES_FALL |-> !level_flag)
		else $error("falling request on high level");
	a_level_track: assert property (req |-> level_flag == s_q.filt && $changed(s_q.filt))
		else $error("level flag not taken at request");
	a_level_hold: assert property (!req && gate_en |-> $stable(level_flag))
		else $error("level flag moved without a request");

endmodule // eif_chan

// ### src/eif_pkg.sv
// =====================================================================
// Shared constants for the two-channel external interrupt filter
// =====================================================================
package eif_pkg;

	// =================================================================
	// Register indices (byte address is four times the index)
	// =================================================================
	localparam logic [11:0] IDX_CTRL2 = 12'hfd9; // Channel 2 control
	localparam logic [11:0] IDX_CTRL3 = 12'hfda; // Channel 3 control
	localparam logic [11:0] IDX_GATE  = 12'hf77; // Per-channel clock gate
	localparam logic [11:0] IDX_MODE  = 12'hfdc; // Operating speed mode
	localparam logic [11:0] IDX_STAT  = 12'hfdd; // Sticky request status
	localparam logic [11:0] IDX_MASK  = 12'hfde; // Interrupt mask

	// =================================================================
	// Field positions
	// =================================================================
	localparam int NC_LSB    = 0; // Sample interval field, two bits
	localparam int ES_LSB    = 2; // Edge select field, two bits
	localparam int LVL_BIT   = 4; // Read-only level flag
	localparam int GATE_LSB  = 2; // Gate bit of channel 2, channel 3 above
	localparam int SLOW_BIT  = 0; // Low-speed mode bit in the mode register
	localparam int NCHAN     = 2; // Channels 2 and 3

	// =================================================================
	// Values after reset
	// =================================================================
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [1:0] GATE_RST = 2'h0;
	localparam logic       SLOW_RST = 1'b0;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;

	// =================================================================
	// Filter acceptance counts, in sample periods
	// =================================================================
	localparam logic [1:0] NEED_FAST = 2'h3; // Three agreeing samples
	localparam logic [1:0] NEED_SLOW = 2'h2; // Two agreeing samples

	// =================================================================
	// Low-frequency clock, derived from the 40 ns bus clock
	// =================================================================
	localparam int CLK_PERIOD_NS = 40;
	localparam int LF_PERIOD_NS  = 30518; // About 32.768 kHz
	localparam int LF_DIV_CYC    = (LF_PERIOD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;

	// Edge selection encodings
	typedef enum logic [1:0] {
		ES_RISE = 2'h0,
		ES_FALL = 2'h1,
		ES_BOTH = 2'h2,
		ES_RSVD = 2'h3
	} eif_edge_t;

endpackage

// ### src/eif_rate.sv
`timescale 1ns/1ps
// =====================================================================
// Sample rate enables: gear rate taps and low-frequency clock / 4
// =====================================================================
module eif_rate #(
	parameter int LF_DIV = eif_pkg::LF_DIV_CYC // Bus cycles per slow period
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	output logic [3:0]      gear_tick,  // Gear / 1, / 4, / 8, / 16
	output logic            lf4_tick    // Low-frequency clock / 4
);
	import eif_pkg::*;

	localparam int LFW = $clog2(LF_DIV);

	// A divide of one would make the slow rate equal the bus rate
	initial begin
		if (LF_DIV < 2) $error("LF_DIV must be at least 2");
	end

	typedef struct packed {
		logic [3:0]     gcnt; // Free gear prescaler
		logic [LFW-1:0] lcnt; // Slow clock divider
		logic [1:0]     q4;   // Slow periods within one sample
	} eif_rate_st_t;

	eif_rate_st_t s_q, s_d;
	logic         lf_pulse;

	// =================================================================
	// Divider chain
	// =================================================================
	always_comb begin
		s_d      = s_q;
		lf_pulse = (s_q.lcnt == LFW'(LF_DIV - 1));
		s_d.gcnt = s_q.gcnt + 4'h1;
		if (lf_pulse) begin
			s_d.lcnt = '0;
			s_d.q4   = s_q.q4 + 2'h1;
		end else begin
			s_d.lcnt = s_q.lcnt + LFW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Tap decode: gear, gear/4, gear/8, gear/16
	assign gear_tick[0] = 1'b1;
	assign gear_tick[1] = (s_q.gcnt[1:0] == 2'h3);
	assign gear_tick[2] = (s_q.gcnt[2:0] == 3'h7);
	assign gear_tick[3] = (s_q.gcnt == 4'hf);
	assign lf4_tick     = lf_pulse && (s_q.q4 == 2'h3);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_div16_gap: assert property (gear_tick[3] |=> !gear_tick[3] [*8])
		else $error("gear/16 tick repeated too soon");
	a_div4_period: assert property (gear_tick[1] |=> !gear_tick[1] ##3 gear_tick[1])
		else $error("gear/4 tick period wrong");

endmodule // eif_rate

// ### src/eif_top.sv
`timescale 1ns/1ps
// What this block does
// - Two independent channels, each own control register
// - Level flag: zero at reset or gate off, else last level
// - Select 00 requests on filtered rising edges
// - Select 01 requests on filtered falling edges
// - Select 10 both edges; 11 is reserved
// - Fast modes sample at gear / 1, 4, 8, 16
// - Slow modes sample at low clock / 4
// - Control bits 7 to 5 read zero
// - Mode changes may cause stray requests
// - Control writes may cause stray requests
// - Gate off stops channel, clears its control
// - Level flag updated at every request
// - Fast: reject under two, accept over three samples
// - Slow: reject under four, accept over eight periods
module eif_top #(
	parameter int ADDR_W = 16,                 // APB address width
	parameter int LF_DIV = eif_pkg::LF_DIV_CYC // Bus cycles per slow period
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              ext_irq_pin_two,
	input  wire logic              ext_irq_pin_three,
	output logic                   chan2_req,
	output logic                   chan3_req,
	output logic                   irq
);
	import eif_pkg::*;

	// The highest index needs fourteen address bits
	initial begin
		if (ADDR_W < 14 || ADDR_W > 32) $error("ADDR_W must be 14 to 32");
	end

	// =================================================================
	// Register state
	// =================================================================
	typedef struct packed {
		logic [NCHAN-1:0][3:0] ctrl;   // Edge select and sample interval
		logic [NCHAN-1:0]      gate;   // Channel clock gate bits
		logic                  slow;   // Low-speed mode selected
		logic [NCHAN-1:0]      status; // Sticky request bits
		logic [NCHAN-1:0]      mask;   // Interrupt enables
		logic                  irq;    // Registered interrupt line
		logic [31:0]           rdata;  // Read data captured in setup
	} eif_top_st_t;

	eif_top_st_t s_q, s_d;

	// Bus decode helpers
	logic [ADDR_W-3:0] word;      // Word index of the access
	logic              aligned;   // Low address bits zero
	logic              hit_ctrl2; // Channel 2 control selected
	logic              hit_ctrl3; // Channel 3 control selected
	logic              hit_gate;  // Clock gate register selected
	logic              hit_mode;  // Mode register selected
	logic              hit_stat;  // Status register selected
	logic              hit_mask;  // Mask register selected
	logic              mapped;    // Any register selected
	logic              setup;     // APB setup cycle
	logic              wr_acc;    // Write access phase
	logic [31:0]       rd_mux;    // Read value before capture

	// Per-channel wires and shared rate taps
	logic [NCHAN-1:0]  pin;        // Raw inputs
	logic [NCHAN-1:0]  req;        // One-cycle requests
	logic [NCHAN-1:0]  level_flag; // Captured levels
	logic [NCHAN-1:0]  sample_tick;// Per-channel sample enable
	logic [3:0]        gear_tick;  // Gear rate taps
	logic              lf4_tick;   // Slow rate tap

	assign pin = {ext_irq_pin_three, ext_irq_pin_two};

	// =================================================================
	// Address decode
	// =================================================================
	assign word      = paddr[ADDR_W-1:2];
	assign aligned   = (paddr[1:0] == 2'h0);
	assign hit_ctrl2 = aligned && (word == (ADDR_W-2)'(IDX_CTRL2));
	assign hit_ctrl3 = aligned && (word == (ADDR_W-2)'(IDX_CTRL3));
	assign hit_gate  = aligned && (word == (ADDR_W-2)'(IDX_GATE));
	assign hit_mode  = aligned && (word == (ADDR_W-2)'(IDX_MODE));
	assign hit_stat  = aligned && (word == (ADDR_W-2)'(IDX_STAT));
	assign hit_mask  = aligned && (word == (ADDR_W-2)'(IDX_MASK));
	assign mapped    = hit_ctrl2 | hit_ctrl3 | hit_gate | hit_mode | hit_stat | hit_mask;
	assign setup     = psel && !penable;
	assign wr_acc    = psel && penable && pwrite;

	// =================================================================
	// Read multiplexer
	// =================================================================
	// Control words carry the live level flag; upper bits stay zero
	always_comb begin
		rd_mux = 32'h0;
		if (hit_ctrl2) begin
			rd_mux[LVL_BIT]  = level_flag[0];
			rd_mux[3:0]      = s_q.ctrl[0];
		end else if (hit_ctrl3) begin
			rd_mux[LVL_BIT]  = level_flag[1];
			rd_mux[3:0]      = s_q.ctrl[1];
		end else if (hit_gate) begin
			rd_mux[GATE_LSB +: NCHAN] = s_q.gate;
		end else if (hit_mode) begin
			rd_mux[SLOW_BIT] = s_q.slow;
		end else if (hit_stat) begin
			rd_mux[NCHAN-1:0] = s_q.status;
		end else if (hit_mask) begin
			rd_mux[NCHAN-1:0] = s_q.mask;
		end else begin
			rd_mux = 32'h0; // Unmapped reads as zero
		end
	end

	// =================================================================
	// Next-state logic for registers
	// =================================================================
	always_comb begin
		s_d = s_q;

		// Read data is frozen in setup so prdata comes from a flop
		if (setup) begin
			s_d.rdata = rd_mux;
		end

		// Register writes land on the access edge
		if (wr_acc) begin
			if (hit_gate) begin
				s_d.gate = pwdata[GATE_LSB +: NCHAN];
			end
			if (hit_mode) begin
				s_d.slow = pwdata[SLOW_BIT];
			end
			if (hit_mask) begin
				s_d.mask = pwdata[NCHAN-1:0];
			end
			// Control writes are lost while the channel clock is off
			if (hit_ctrl2 && s_q.gate[0]) begin
				s_d.ctrl[0] = pwdata[3:0];
			end
			if (hit_ctrl3 && s_q.gate[1]) begin
				s_d.ctrl[1] = pwdata[3:0];
			end
		end

		// A stopped channel clock invalidates its control contents
		for (int i = 0; i < NCHAN; i++) begin
			if (!s_d.gate[i]) begin
				s_d.ctrl[i] = CTRL_RST;
			end
		end

		// Write one to clear; a request in the same cycle wins
		if (wr_acc && hit_stat) begin
			s_d.status = s_q.status & ~pwdata[NCHAN-1:0];
		end
		s_d.status = s_d.status | req;

		// Interrupt line follows status and mask without lag
		s_d.irq = |(s_d.status & s_d.mask);
	end

	// =================================================================
	// State register
	// =================================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.ctrl   <= {NCHAN{CTRL_RST}};
			s_q.gate   <= GATE_RST;
			s_q.slow   <= SLOW_RST;
			s_q.status <= STAT_RST;
			s_q.mask   <= MASK_RST;
			s_q.irq    <= 1'b0;
			s_q.rdata  <= 32'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// =================================================================
	// Bus answers
	// =================================================================
	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = s_q.rdata;
	assign irq     = s_q.irq;

	// =================================================================
	// Sample rate generator shared by both channels
	// =================================================================
	eif_rate #(
		.LF_DIV (LF_DIV)
	) u_rate (
		.pclk      (pclk),
		.presetn   (presetn),
		.gear_tick (gear_tick),
		.lf4_tick  (lf4_tick)
	);

	// =================================================================
	// Channels
	// =================================================================
	// Mode switches change the rate mid-filter, which may fire a stray
	// request; software masks the interrupt around such switches
	for (genvar g = 0; g < NCHAN; g++) begin : g_chan
		// Slow mode ignores the interval field entirely
		assign sample_tick[g] = s_q.slow ? lf4_tick
			: gear_tick[s_q.ctrl[g][NC_LSB +: 2]];

		eif_chan u_chan (
			.pclk        (pclk),
			.presetn     (presetn),
			.gate_en     (s_q.gate[g]),
			.slow_mode   (s_q.slow),
			.sample_tick (sample_tick[g]),
			.edge_sel    (eif_edge_t'(s_q.ctrl[g][ES_LSB +: 2])),
			.pin         (pin[g]),
			.req         (req[g]),
			.level_flag  (level_flag[g])
		);
	end

	assign chan2_req = req[0];
	assign chan3_req = req[1];

	// =================================================================
	// Checks
	// =================================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Control read shows no reserved bits
	a_ctrl_reserved: assert property (
		psel && penable && !pwrite && (hit_ctrl2 || hit_ctrl3) |-> prdata[31:5] == 27'h0)
		else $error("reserved control bits read nonzero");

	// Gate off leaves the control word cleared
	a_gate_clears: assert property (!s_q.gate[0] |-> s_q.ctrl[0] == CTRL_RST)
		else $error("channel 2 control kept with gate off");

	// Gated writes are dropped
	a_gate_blocks: assert property (
		wr_acc && hit_ctrl3 && !s_q.gate[1] |=> s_q.ctrl[1] == CTRL_RST)
		else $error("channel 3 control written with gate off");

	// Written control reaches the register
	a_ctrl_write: assert property (
		wr_acc && hit_ctrl2 && s_q.gate[0] && s_d.gate[0]
		|=> s_q.ctrl[0] == $past(pwdata[3:0]))
		else $error("channel 2 control write lost");

	// Slow mode uses the slow tap for every interval value
	a_slow_rate: assert property (s_q.slow |-> sample_tick == {NCHAN{lf4_tick}})
		else $error("slow mode not at low clock / 4");

	// Interval 00 samples every gear cycle
	a_fast_rate: assert property (
		!s_q.slow && s_q.ctrl[1][NC_LSB +: 2] == 2'h0 |-> sample_tick[1])
		else $error("interval 00 missed a gear sample");

	// A request sets its sticky bit even against a clear
	a_set_wins: assert property (req[0] |=> s_q.status[0])
		else $error("channel 2 request lost in status");

	// Interrupt line matches masked status
	a_irq_level: assert property (##1 irq == |(s_q.status & s_q.mask))
		else $error("interrupt line out of step");

	// Unmapped access reports an error
	a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access not flagged");

	c_rise_req: cover property (req[0] && level_flag[0]);
	c_fall_req: cover property (req[1] && !level_flag[1]);
	c_slow_req: cover property (s_q.slow && req[0]);
	c_irq_set: cover property (!irq ##1 irq);

endmodule // eif_top

// ### tb/eif_src.sv
`timescale 1ns/1ps
// =====================================================================
// External signal source: drives one raw interrupt pin
// =====================================================================
module eif_src (
	input  wire logic       pclk, // Bus clock, source stays synchronous
	input  wire logic       go,   // Start one high pulse
	input  wire logic [7:0] len,  // Pulse width in bus cycles
	output logic            pin   // Raw pin level
);
	logic [7:0] left_q = 8'h00; // Cycles of pulse still to drive, idle at start

	// Pulse length counter; a new go restarts the pulse
	always @(posedge pclk) begin
		if (go) begin
			left_q <= len;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end

	// Pin idles low, like a source with a pull-down
	assign pin = (left_q != 8'h00);

endmodule // eif_src

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
	import eif_pkg::*;
	// =================================================================
	// Signals
	// =================================================================
	localparam int LFD = 2; // Short slow period keeps the run brief
	typedef struct {
		logic [1:0] nc;
		logic [1:0] es;
		int         len;
		int         nreq;
		logic       lvl;
	} eif_row_t;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, irq, chan2_req, chan3_req;
	logic        pin2, pin3, go2 = 1'b0, go3 = 1'b0, counting = 1'b0;
	logic [7:0]  len = 8'h00;
	int          n_fail = 0, cmp_count = 0, cnt2, cnt3;
	logic [11:0] ridx[6] = '{IDX_CTRL2, IDX_CTRL3, IDX_GATE, IDX_MODE, IDX_STAT, IDX_MASK};
	// Interval, select, pulse width, requests, level afterwards
	eif_row_t    rows[11] = '{
		'{2'h0, 2'h0, 8, 1, 1'b1}, '{2'h0, 2'h1, 8, 1, 1'b0}, '{2'h0, 2'h2, 8, 2, 1'b0},
		'{2'h0, 2'h3, 8, 0, 1'b0}, '{2'h0, 2'h2, 1, 0, 1'b0}, '{2'h1, 2'h2, 20, 2, 1'b0},
		'{2'h1, 2'h2, 4, 0, 1'b0}, '{2'h2, 2'h2, 40, 2, 1'b0}, '{2'h2, 2'h2, 8, 0, 1'b0},
		'{2'h3, 2'h2, 80, 2, 1'b0}, '{2'h3, 2'h2, 16, 0, 1'b0}};

	always #20 pclk = ~pclk;

	// =================================================================
	// Design and pin sources
	// =================================================================
	eif_top #(.ADDR_W(16), .LF_DIV(LFD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_pin_two(pin2), .ext_irq_pin_three(pin3),
		.chan2_req(chan2_req), .chan3_req(chan3_req), .irq(irq));
	eif_src u_src2 (.pclk(pclk), .go(go2), .len(len), .pin(pin2));
	eif_src u_src3 (.pclk(pclk), .go(go3), .len(len), .pin(pin3));

	// Request counters; sees each one-cycle pulse once
	always @(posedge pclk) begin
		if (counting) begin
			cnt2 += (chan2_req === 1'b1);
			cnt3 += (chan3_req === 1'b1);
		end
	end

	// =================================================================
	// Tasks
	// =================================================================
	task automatic tally_and_finish;
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp, input string what);
		cmp_count++;
		if (got != exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	// One APB transfer; waits for pready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 32);
		if (pready !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t bus answer never came", $time);
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// One pin pulse, counting requests for a fixed window after it
	task automatic measure(input int ch, input int l, input int w);
		cnt2 = 0;
		cnt3 = 0;
		counting <= 1'b1;
		len <= 8'(l);
		if (ch == 0) go2 <= 1'b1;
		else go3 <= 1'b1;
		@(posedge pclk);
		go2 <= 1'b0;
		go3 <= 1'b0;
		repeat (l + w) @(posedge pclk);
		counting <= 1'b0;
		@(posedge pclk);
	endtask

	// =================================================================
	// Main sequence
	// =================================================================
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ridx[i]) begin
			apb(1'b0, ridx[i], 32'h0);
			chk_word(rd, 32'h0, "reset value");
		end
		apb(1'b1, IDX_GATE, 32'hc);
		foreach (rows[r]) begin
			for (int ch = 0; ch < 2; ch++) begin
				apb(1'b1, ch ? IDX_CTRL3 : IDX_CTRL2, {28'h0, rows[r].es, rows[r].nc});
				// Stray requests after a control write are allowed, so let them pass
				repeat (40) @(posedge pclk);
				apb(1'b1, IDX_STAT, 32'h3);
				measure(ch, rows[r].len, 100);
				chk_cnt(ch ? cnt3 : cnt2, rows[r].nreq, "requests");
				chk_cnt(ch ? cnt2 : cnt3, 0, "other channel");
				apb(1'b0, ch ? IDX_CTRL3 : IDX_CTRL2, 32'h0);
				chk_word(rd, {27'h0, rows[r].lvl, rows[r].es, rows[r].nc}, "control");
				apb(1'b0, IDX_STAT, 32'h0);
				chk_word(rd, (rows[r].nreq > 0) ? 32'(1 << ch) : 32'h0, "status");
				chk_word({31'h0, irq}, 32'h0, "irq masked");
			end
		end
		// Interrupt raise, clear and mask
		apb(1'b1, IDX_CTRL2, 32'h0);
		repeat (40) @(posedge pclk);
		apb(1'b1, IDX_STAT, 32'h3);
		apb(1'b1, IDX_MASK, 32'h1);
		measure(0, 8, 100);
		chk_word({31'h0, irq}, 32'h1, "irq raised");
		apb(1'b1, IDX_STAT, 32'h1);
		chk_word({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'b1, IDX_MASK, 32'h2);
		measure(0, 8, 100);
		chk_word({31'h0, irq}, 32'h0, "irq other mask");
		// Slow mode: interval field ignored, longer filter
		apb(1'b1, IDX_MASK, 32'h0);
		apb(1'b1, IDX_MODE, 32'h1);
		repeat (12 * LFD + 40) @(posedge pclk);
		apb(1'b1, IDX_CTRL2, 32'hb);
		repeat (40) @(posedge pclk);
		apb(1'b1, IDX_STAT, 32'h3);
		measure(0, 6, 200);
		chk_cnt(cnt2, 0, "slow short pulse");
		measure(0, 24, 200);
		chk_cnt(cnt2, 2, "slow long pulse");
		apb(1'b1, IDX_MODE, 32'h0);
		repeat (60) @(posedge pclk);
		// Gate off: control lost, writes dropped, no requests
		apb(1'b1, IDX_GATE, 32'h8);
		apb(1'b0, IDX_CTRL2, 32'h0);
		chk_word(rd, 32'h0, "gated control");
		apb(1'b1, IDX_CTRL2, 32'h8);
		apb(1'b0, IDX_CTRL2, 32'h0);
		chk_word(rd, 32'h0, "gated write");
		measure(0, 8, 100);
		chk_cnt(cnt2, 0, "gated requests");
		// Unmapped address
		apb(1'b0, 12'h000, 32'h0);
		chk_word({31'h0, err}, 32'h1, "unmapped error");
		chk_word(rd, 32'h0, "unmapped data");
		// Second reset in mid-run
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, IDX_CTRL3, 32'h0);
		chk_word(rd, 32'h0, "control after reset");
		tally_and_finish();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule // tb
